/* File: epc_check_assertions.sv */
// Concurrent checks on the counter unit bus handshake and pin views
`timescale 1ns/10ps
module epc_check (
    // Clock and reset
    input wire logic clk_in,
    input wire logic nrst_in,
    // Register bus
    input wire logic [7:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_readdata_out,
    input wire logic avs_waitrequest_out,
    // Pins and synchronised views
    input wire logic serial_encoder_data_in,
    input wire logic [11:0] isolated_input_in,
    input wire logic serial_data_sync_out,
    input wire logic [11:0] isolated_level_out
);
    // Sync views only settle three edges after reset release
    logic [1:0] age_q;
    logic [1:0] age_d;
    always_comb age_d = (age_q == 2'h3) ? age_q : age_q + 2'h1;
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) age_q <= 2'h0;
        else age_q <= age_d;
    end
    default clocking @(posedge clk_in); endclocking
    default disable iff (!nrst_in);
    sequence s_req;
        (avs_read_in || avs_write_in) && avs_waitrequest_out;
    endsequence
    sequence s_ans;
        !avs_waitrequest_out ##1 avs_waitrequest_out;
    endsequence
    sequence s_rd_ans;
        avs_read_in && !avs_waitrequest_out;
    endsequence
    property p_answer;
        s_req |=> s_ans;
    endproperty
    property p_quiet;
        !avs_read_in && !avs_write_in |=> avs_waitrequest_out;
    endproperty
    property p_stand;
        avs_waitrequest_out && $past(avs_waitrequest_out) |-> $stable(avs_readdata_out);
    endproperty
    property p_din;
        age_q == 2'h3 |-> isolated_level_out == $past(isolated_input_in, 3);
    endproperty
    property p_ser;
        age_q == 2'h3 |-> serial_data_sync_out == $past(serial_encoder_data_in, 3);
    endproperty
    property p_unmapped;
        s_rd_ans and (avs_address_in > 8'h40) |-> avs_readdata_out == 32'h00000000;
    endproperty
    property p_cmd_zero;
        s_rd_ans and (avs_address_in < 8'h40) and (avs_address_in[4:0] == 5'h04)
            |-> avs_readdata_out == 32'h00000000;
    endproperty
    property p_ctrl_width;
        s_rd_ans and (avs_address_in < 8'h40) and (avs_address_in[4:0] == 5'h00)
            |-> avs_readdata_out[31:12] == 20'h00000;
    endproperty
    a_answer: assert property (p_answer) else $error("request not answered in one cycle");
    a_quiet: assert property (p_quiet) else $error("answer without request");
    a_stand: assert property (p_stand) else $error("read data moved between answers");
    a_din: assert property (p_din) else $error("isolated levels wrong");
    a_ser: assert property (p_ser) else $error("serial level wrong");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    a_cmd_zero: assert property (p_cmd_zero) else $error("command read not zero");
    a_ctrl_width: assert property (p_ctrl_width) else $error("control spare bits set");
endmodule : epc_check
bind epc_top epc_check u_check (.clk_in(clk_in), .nrst_in(nrst_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
    .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
    .serial_encoder_data_in(serial_encoder_data_in), .isolated_input_in(isolated_input_in),
    .serial_data_sync_out(serial_data_sync_out), .isolated_level_out(isolated_level_out));

/* File: epc_pkg.sv */
// Types shared by the counter unit modules
package epc_pkg;

    // Per-block configuration, bit 0 is enable
    typedef struct packed {
        logic pwm_enable;
        logic pwm_edge;
        logic [1:0] pwm_src;
        logic ref_only;
        logic external_capture_arm;
        logic external_clear_arm;
        logic capture_select;
        logic inv_dir;
        logic inv_clk;
        logic quad_mode;
        logic enable;
    } epc_mode_t;

    // One counter block: up/down counter plus pulse width counter
    typedef struct packed {
        epc_mode_t counter_mode_config;
        logic [31:0] count;
        logic [31:0] capture;
        logic [31:0] pw_run;
        logic [31:0] stage_high;
        logic [31:0] stage_low;
        logic [31:0] pw_high;
        logic [31:0] pw_low;
        logic last_up;
    } epc_blk_t;

    // Whole top-level state
    typedef struct packed {
        epc_blk_t [1:0] blk;
        logic ack;
        logic waitreq;
        logic [31:0] rdata;
    } epc_state_t;

    // Synchronised pin view of one block: bit 0 A/clock, 1 B/direction, 2 clear/capture
    typedef struct packed {
        logic [2:0] lvl;
        logic [2:0] rise;
        logic [2:0] fall;
    } epc_pins_t;

endpackage : epc_pkg

/* File: epc_regs.svh */
// Register offsets, field positions and reset values of the counter unit
`ifndef EPC_REGS_SVH
`define EPC_REGS_SVH

// Byte addresses, block base is index times stride
`define EPC_BLK_STRIDE 8'h20
`define EPC_BLK_LIMIT 8'h40
`define EPC_OFF_CTRL 5'h00
`define EPC_OFF_CMD 5'h04
`define EPC_OFF_COUNT 5'h08
`define EPC_OFF_CAPTURE 5'h0C
`define EPC_OFF_PW_HIGH 5'h10
`define EPC_OFF_PW_LOW 5'h14
`define EPC_OFF_PERIOD 5'h18
`define EPC_OFF_STATUS 5'h1C
`define EPC_OFF_DIN 8'h40

// Command bits, write-one pulses
`define EPC_CMD_CLEAR 0
`define EPC_CMD_CAPTURE 1
`define EPC_CMD_PW_CLEAR 2

// Control field positions
`define EPC_CTRL_WIDTH 12
`define EPC_CTRL_RESET 12'h000

// PWM source select codes
`define EPC_SRC_A 2'h0
`define EPC_SRC_B 2'h1
`define EPC_SRC_CLR 2'h2

// Fixed values
`define EPC_ONE 32'h00000001
`define EPC_MAX 32'hFFFFFFFF
`define EPC_ZERO 32'h00000000

`endif

/* File: epc_src_model.sv */
// Encoder and pulse source driving one counter block's pins
`timescale 1ns/10ps
module epc_src_model (
    // Clock
    input wire logic clk_in,
    // Pin lines
    output logic a_out,
    output logic b_out,
    output logic r_out
);
    int pos;
    initial begin
        {a_out, b_out, r_out} = 3'h0;
        pos = 0;
    end
    // Levels change on an edge and stand n cycles
    task automatic put(input logic [2:0] v, input int n);
        @(posedge clk_in);
        {a_out, b_out, r_out} <= v;
        repeat (n - 1) @(posedge clk_in);
    endtask : put
    // Gray order 00 01 11 10 is the up sense
    task automatic quad(input bit up);
        logic [1:0] g;
        pos = up ? pos + 1 : pos - 1;
        g = pos[1:0] ^ {1'b0, pos[1]};
        put({g, r_out}, 2);
    endtask : quad
    task automatic pulses(input int sel, input int h, input int l, input int reps);
        logic [2:0] m;
        m = 3'h4 >> sel;
        repeat (reps) begin
            put({a_out, b_out, r_out} | m, h);
            put({a_out, b_out, r_out} & ~m, l);
        end
    endtask : pulses
endmodule : epc_src_model

/* File: epc_sync.sv */
// Two-stage pin synchroniser with registered level and edge pulses
`timescale 1ns/10ps
module epc_sync #(
    parameter int WIDTH = 3
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic nrst_in,
    // Asynchronous pins
    input wire logic [WIDTH-1:0] pin_in,
    // Synchronised view
    output logic [WIDTH-1:0] level_out,
    output logic [WIDTH-1:0] rise_out,
    output logic [WIDTH-1:0] fall_out
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] sync;
        logic [WIDTH-1:0] level;
        logic [WIDTH-1:0] rise;
        logic [WIDTH-1:0] fall;
    } epc_sync_state_t;

    epc_sync_state_t s_q;
    epc_sync_state_t s_d;

    // First stage feeds only the second; edges come from later stages
    always_comb begin
        s_d = s_q;
        s_d.meta = pin_in;
        s_d.sync = s_q.meta;
        s_d.level = s_q.sync;
        s_d.rise = s_q.sync & ~s_q.level;
        s_d.fall = ~s_q.sync & s_q.level;
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign level_out = s_q.level;
    assign rise_out = s_q.rise;
    assign fall_out = s_q.fall;

endmodule : epc_sync

/* File: epc_top.sv */
// Two-block encoder and pulse width counter unit with Avalon-MM register slave
//
// Overview of operation
// - Two blocks each hold a 32-bit up/down counter and a pulse width counter running together.
// - In clock/direction mode the counter steps by one on each falling edge of the clock input.
// - In clock/direction mode a high direction level counts up and a low level counts down.
// - Clock and direction may each be inverted, moving the active edge and reversing the sense.
// - A software command copies the running count into the capture register without disturbing it.
// - Software selects whether the clear/capture pin clears or captures; it acts only once software has armed it.
// - When armed, a rising edge on the clear/capture pin clears or captures the counter.
// - Four-edge mode decodes quadrature A/B into one count per edge on either input.
// - In four-edge mode an armed clear holds the count at zero while A, B and reference are 1.
// - The pulse width counter measures A, B or clear/capture with a selectable trigger edge.
// - Software reads high time, low time and period, giving frequency and duty cycle.
// - Block 2 pins are isolated inputs 0 to 2, which stay readable as plain inputs.
// - The serial encoder data pin is also the clear/capture input of block 1.
//
// Implementation choices: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`include "epc_regs.svh"
module epc_top (
    // Clock and reset
    input wire logic clk_in,
    input wire logic nrst_in,
    // Avalon-MM slave
    input wire logic [7:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    // Block 1 differential pins
    input wire logic cnt1_a_in,
    input wire logic cnt1_b_in,
    input wire logic serial_encoder_data_in,
    // Isolated inputs, bits 0 to 2 also feed block 2
    input wire logic [11:0] isolated_input_in,
    // Synchronised pin views for the neighbouring functions
    output logic serial_data_sync_out,
    output logic [11:0] isolated_level_out
);

    epc_pkg::epc_state_t s_q;
    epc_pkg::epc_state_t s_d;
    epc_pkg::epc_pins_t pins [2];

    logic [2:0] b1_lvl;
    logic [2:0] b1_rise;
    logic [2:0] b1_fall;
    logic [11:0] iso_lvl;
    logic [11:0] iso_rise;
    logic [11:0] iso_fall;

    // Block 1 pins, serial data doubles as clear/capture
    epc_sync #(
        .WIDTH(3)
    ) u_sync_blk1 (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .pin_in({serial_encoder_data_in, cnt1_b_in, cnt1_a_in}),
        .level_out(b1_lvl),
        .rise_out(b1_rise),
        .fall_out(b1_fall)
    );

    // All isolated inputs, the low three also feed block 2
    epc_sync #(
        .WIDTH(12)
    ) u_sync_iso (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .pin_in(isolated_input_in),
        .level_out(iso_lvl),
        .rise_out(iso_rise),
        .fall_out(iso_fall)
    );

    always_comb begin
        pins[0].lvl = b1_lvl;
        pins[0].rise = b1_rise;
        pins[0].fall = b1_fall;
        pins[1].lvl = iso_lvl[2:0];
        pins[1].rise = iso_rise[2:0];
        pins[1].fall = iso_fall[2:0];
    end

    // Address decode result
    logic hit_blk;
    logic blk_sel;
    logic [4:0] reg_off;
    logic hit_din;

    always_comb begin
        hit_blk = 1'b0;
        hit_din = 1'b0;
        blk_sel = avs_address_in[5];
        reg_off = avs_address_in[4:0];
        if (avs_address_in < `EPC_BLK_LIMIT) begin
            hit_blk = 1'b1;
        end else if (avs_address_in == `EPC_OFF_DIN) begin
            hit_din = 1'b1;
        end
    end

    // Merge write data into a 12-bit control word by byte lane
    function automatic epc_pkg::epc_mode_t epc_merge_mode(
        input epc_pkg::epc_mode_t old_mode,
        input logic [31:0] wdata,
        input logic [3:0] be
    );
        logic [15:0] w;
        w = {4'h0, old_mode};
        if (be[0]) begin
            w[7:0] = wdata[7:0];
        end
        if (be[1]) begin
            w[15:8] = wdata[15:8];
        end
        return epc_pkg::epc_mode_t'(w[`EPC_CTRL_WIDTH-1:0]);
    endfunction : epc_merge_mode

    // Read mux of one block
    function automatic logic [31:0] epc_read_blk(
        input epc_pkg::epc_blk_t b,
        input epc_pkg::epc_pins_t p,
        input logic [4:0] off
    );
        logic [31:0] r;
        r = `EPC_ZERO;
        if (off == `EPC_OFF_CTRL) begin
            r = {20'h00000, b.counter_mode_config};
        end else if (off == `EPC_OFF_COUNT) begin
            r = b.count;
        end else if (off == `EPC_OFF_CAPTURE) begin
            r = b.capture;
        end else if (off == `EPC_OFF_PW_HIGH) begin
            r = b.pw_high;
        end else if (off == `EPC_OFF_PW_LOW) begin
            r = b.pw_low;
        end else if (off == `EPC_OFF_PERIOD) begin
            r = b.pw_high + b.pw_low;
        end else if (off == `EPC_OFF_STATUS) begin
            r = {28'h0000000, p.lvl, b.last_up};
        end
        return r;
    endfunction : epc_read_blk

    // Working variables of the block update
    logic cmd_clear [2];
    logic cmd_capture [2];
    logic cmd_pw_clear [2];
    logic step [2];
    logic up [2];
    logic ext_clear [2];
    logic ext_capture [2];
    logic cd_edge [2];
    logic a_chg [2];
    logic b_chg [2];
    logic a_prev [2];
    logic ref_hold [2];
    logic [1:0] src [2];
    logic sel_rise [2];
    logic sel_fall [2];
    logic trig [2];
    logic [31:0] new_high [2];
    logic [31:0] new_low [2];

    always_comb begin
        s_d = s_q;

        // Avalon: waitrequest idles high, drops for one cycle per request
        s_d.ack = 1'b0;
        s_d.waitreq = 1'b1;
        if ((avs_read_in || avs_write_in) && !s_q.ack) begin
            s_d.ack = 1'b1;
            s_d.waitreq = 1'b0;
            s_d.rdata = `EPC_ZERO;
            if (avs_read_in && hit_blk) begin
                s_d.rdata = epc_read_blk(s_q.blk[blk_sel], pins[blk_sel], reg_off);
            end else if (avs_read_in && hit_din) begin
                s_d.rdata = {20'h00000, iso_lvl};
            end
        end

        for (int i = 0; i < 2; i++) begin
            cmd_clear[i] = 1'b0;
            cmd_capture[i] = 1'b0;
            cmd_pw_clear[i] = 1'b0;
            // Writes land at the edge where the master sees waitrequest low
            if (s_q.ack && avs_write_in && hit_blk && (blk_sel == i[0])) begin
                if (reg_off == `EPC_OFF_CTRL) begin
                    s_d.blk[i].counter_mode_config = epc_merge_mode(
                        s_q.blk[i].counter_mode_config, avs_writedata_in, avs_byteenable_in);
                end else if (reg_off == `EPC_OFF_CMD && avs_byteenable_in[0]) begin
                    cmd_clear[i] = avs_writedata_in[`EPC_CMD_CLEAR];
                    cmd_capture[i] = avs_writedata_in[`EPC_CMD_CAPTURE];
                    cmd_pw_clear[i] = avs_writedata_in[`EPC_CMD_PW_CLEAR];
                end
            end

            // Clock/direction decode
            cd_edge[i] = s_q.blk[i].counter_mode_config.inv_clk ?
                pins[i].rise[0] : pins[i].fall[0];
            // Quadrature decode; a simultaneous A and B change is illegal and dropped
            a_chg[i] = pins[i].rise[0] | pins[i].fall[0];
            b_chg[i] = pins[i].rise[1] | pins[i].fall[1];
            a_prev[i] = pins[i].lvl[0] ^ a_chg[i];
            if (s_q.blk[i].counter_mode_config.quad_mode) begin
                step[i] = a_chg[i] ^ b_chg[i];
                up[i] = a_prev[i] ^ pins[i].lvl[1];
            end else begin
                step[i] = cd_edge[i];
                up[i] = pins[i].lvl[1] ^ s_q.blk[i].counter_mode_config.inv_dir;
            end

            // External clear/capture only once armed
            ref_hold[i] = s_q.blk[i].counter_mode_config.ref_only ? pins[i].lvl[2] :
                (pins[i].lvl[0] & pins[i].lvl[1] & pins[i].lvl[2]);
            if (s_q.blk[i].counter_mode_config.quad_mode) begin
                ext_clear[i] = ref_hold[i];
            end else begin
                ext_clear[i] = pins[i].rise[2];
            end
            ext_clear[i] = ext_clear[i] && !s_q.blk[i].counter_mode_config.capture_select &&
                s_q.blk[i].counter_mode_config.external_clear_arm;
            ext_capture[i] = pins[i].rise[2] &&
                s_q.blk[i].counter_mode_config.capture_select &&
                s_q.blk[i].counter_mode_config.external_capture_arm;

            // Capture sees the count before this cycle's step
            if (cmd_capture[i] || ext_capture[i]) begin
                s_d.blk[i].capture = s_q.blk[i].count;
            end
            if (cmd_clear[i] || ext_clear[i]) begin
                s_d.blk[i].count = `EPC_ZERO;
            end else if (s_q.blk[i].counter_mode_config.enable && step[i]) begin
                // Plain 32-bit add wraps in both directions
                s_d.blk[i].count = up[i] ? s_q.blk[i].count + `EPC_ONE :
                    s_q.blk[i].count - `EPC_ONE;
                s_d.blk[i].last_up = up[i];
            end

            // Pulse width counter runs alongside the up/down counter
            src[i] = s_q.blk[i].counter_mode_config.pwm_src;
            if (src[i] == `EPC_SRC_B) begin
                sel_rise[i] = pins[i].rise[1];
                sel_fall[i] = pins[i].fall[1];
            end else if (src[i] == `EPC_SRC_CLR) begin
                sel_rise[i] = pins[i].rise[2];
                sel_fall[i] = pins[i].fall[2];
            end else begin
                sel_rise[i] = pins[i].rise[0];
                sel_fall[i] = pins[i].fall[0];
            end
            trig[i] = s_q.blk[i].counter_mode_config.pwm_edge ? sel_fall[i] : sel_rise[i];
            new_high[i] = sel_fall[i] ? s_q.blk[i].pw_run : s_q.blk[i].stage_high;
            new_low[i] = sel_rise[i] ? s_q.blk[i].pw_run : s_q.blk[i].stage_low;
            if (cmd_pw_clear[i] || !s_q.blk[i].counter_mode_config.pwm_enable) begin
                s_d.blk[i].pw_run = `EPC_ZERO;
                s_d.blk[i].stage_high = `EPC_ZERO;
                s_d.blk[i].stage_low = `EPC_ZERO;
                if (cmd_pw_clear[i]) begin
                    s_d.blk[i].pw_high = `EPC_ZERO;
                    s_d.blk[i].pw_low = `EPC_ZERO;
                end
            end else begin
                s_d.blk[i].stage_high = new_high[i];
                s_d.blk[i].stage_low = new_low[i];
                // Saturate so a stopped signal reads as very long, not short
                if (sel_rise[i] || sel_fall[i]) begin
                    s_d.blk[i].pw_run = `EPC_ONE;
                end else if (s_q.blk[i].pw_run != `EPC_MAX) begin
                    s_d.blk[i].pw_run = s_q.blk[i].pw_run + `EPC_ONE;
                end
                // Publish a consistent high/low pair only on the trigger edge
                if (trig[i]) begin
                    s_d.blk[i].pw_high = new_high[i];
                    s_d.blk[i].pw_low = new_low[i];
                end
            end
        end
    end

    // One register set for both blocks, both counters per block in parallel
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            s_q <= '0;
            s_q.waitreq <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign avs_readdata_out = s_q.rdata;
    assign avs_waitrequest_out = s_q.waitreq;
    assign serial_data_sync_out = b1_lvl[2];
    assign isolated_level_out = iso_lvl;

endmodule : epc_top

/* File: tb_top.sv */
// Self-checking bench for the two-block counter unit
`timescale 1ns/10ps
module tb_top;
    logic clk_in, nrst_in, avs_read_in, avs_write_in;
    logic [7:0] avs_address_in;
    logic [31:0] avs_writedata_in, avs_readdata_out, q, seed, cap;
    logic [3:0] avs_byteenable_in;
    logic avs_waitrequest_out, serial_data_sync_out;
    wire logic a0_w, b0_w, r0_w;
    wire logic [11:0] iso_w;
    logic [11:0] isolated_level_out;
    logic [8:0] hi_q;
    int n_mismatch, samples_checked, exp0, exp1, h, l;
    assign iso_w[11:3] = hi_q;
    epc_top dut (.clk_in(clk_in), .nrst_in(nrst_in), .avs_address_in(avs_address_in),
        .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
        .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
        .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
        .cnt1_a_in(a0_w), .cnt1_b_in(b0_w), .serial_encoder_data_in(r0_w),
        .isolated_input_in(iso_w), .serial_data_sync_out(serial_data_sync_out),
        .isolated_level_out(isolated_level_out));
    epc_src_model enc0 (.clk_in(clk_in), .a_out(a0_w), .b_out(b0_w), .r_out(r0_w));
    epc_src_model enc1 (.clk_in(clk_in), .a_out(iso_w[0]), .b_out(iso_w[1]), .r_out(iso_w[2]));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    // Hold the request until waitrequest is sampled low
    task automatic bus(input bit wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_in);
        avs_address_in <= a;
        avs_writedata_in <= d;
        avs_write_in <= wr;
        avs_read_in <= !wr;
        n = 0;
        do begin
            @(posedge clk_in);
            n++;
        end while (avs_waitrequest_out !== 1'b0 && n < 50);
        q = avs_readdata_out;
        if (n >= 50) n_mismatch++;
        avs_write_in <= 1'b0;
        avs_read_in <= 1'b0;
    endtask : bus
    task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] exp);
        repeat (6) @(posedge clk_in);
        bus(1'b0, a, 32'h00000000);
        chk(nm, q, exp);
    endtask : rd
    task automatic finish_test;
        $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : finish_test
    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end
    initial begin
        repeat (20000) @(posedge clk_in);
        n_mismatch++;
        finish_test();
    end
    initial begin
        {nrst_in, avs_read_in, avs_write_in, avs_address_in, avs_writedata_in} = '0;
        avs_byteenable_in = 4'hF;
        hi_q = 9'h000;
        seed = 32'h4492241E;
        {n_mismatch, samples_checked, exp0, exp1} = '0;
        repeat (12) @(posedge clk_in);
        nrst_in <= 1'b1;
        rd("ctrl0", 8'h00, 32'h00000000);
        rd("count0", 8'h08, 32'h00000000);
        rd("cmd0", 8'h04, 32'h00000000);
        bus(1'b1, 8'h00, 32'h00000001);
        for (int i = 0; i < 20; i++) begin
            seed = lfsr(seed);
            enc0.put({1'b1, seed[0], 1'b0}, 2);
            enc0.put({1'b0, seed[0], 1'b0}, 2);
            exp0 += seed[0] ? 1 : -1;
        end
        rd("count0", 8'h08, 32'(exp0));
        // Inverted clock counts on its rise, inverted high direction counts down
        bus(1'b1, 8'h00, 32'h0000000D);
        enc0.put(3'h6, 4);
        enc0.put(3'h2, 4);
        exp0 -= 1;
        rd("count0", 8'h08, 32'(exp0));
        bus(1'b1, 8'h04, 32'h00000002);
        rd("capture0", 8'h0C, 32'(exp0));
        rd("count0", 8'h08, 32'(exp0));
        bus(1'b1, 8'h04, 32'h00000001);
        enc0.put(3'h6, 4);
        enc0.put(3'h2, 4);
        rd("count0", 8'h08, 32'hFFFFFFFF);
        enc0.put(3'h3, 4);
        enc0.put(3'h2, 4);
        rd("count0", 8'h08, 32'hFFFFFFFF);
        bus(1'b1, 8'h00, 32'h0000002D);
        enc0.put(3'h3, 4);
        enc0.put(3'h2, 4);
        rd("count0", 8'h08, 32'h00000000);
        enc0.put(3'h6, 4);
        bus(1'b1, 8'h00, 32'h0000005D);
        enc0.put(3'h7, 4);
        enc0.put(3'h2, 4);
        rd("capture0", 8'h0C, 32'hFFFFFFFF);
        rd("count0", 8'h08, 32'hFFFFFFFF);
        bus(1'b1, 8'h20, 32'h00000003);
        for (int i = 0; i < 40; i++) begin
            seed = lfsr(seed);
            enc1.quad(seed[0]);
            exp1 += seed[0] ? 1 : -1;
        end
        rd("count1", 8'h28, 32'(exp1));
        // Two captures a known step count apart must differ by that step count
        bus(1'b1, 8'h24, 32'h00000002);
        rd("capture1", 8'h2C, 32'(exp1));
        cap = q;
        for (int i = 0; i < 5; i++) begin
            enc1.quad(1'b1);
        end
        exp1 += 5;
        rd("count1", 8'h28, 32'(exp1));
        bus(1'b1, 8'h24, 32'h00000002);
        rd("capture1", 8'h2C, 32'(exp1));
        chk("capture_delta", q - cap, 32'h00000005);
        bus(1'b1, 8'h20, 32'h00000023);
        enc1.put({iso_w[0], iso_w[1], 1'b1}, 4);
        if (iso_w[0] && iso_w[1]) exp1 = 0;
        for (int i = 0; i < 4; i++) begin
            enc1.quad(1'b1);
            exp1 = (iso_w[0] && iso_w[1]) ? 0 : exp1 + 1;
        end
        enc1.put({iso_w[0], iso_w[1], 1'b0}, 4);
        rd("count1", 8'h28, 32'(exp1));
        bus(1'b1, 8'h20, 32'h000000A3);
        enc1.put({iso_w[0], iso_w[1], 1'b1}, 4);
        rd("count1", 8'h28, 32'h00000000);
        rd("status1", 8'h3C, {28'h0000000, iso_w[2:0], 1'b1});
        enc0.put(3'h0, 4);
        for (int k = 0; k < 6; k++) begin
            seed = lfsr(seed);
            h = 3 + seed[2:0];
            l = 3 + seed[5:3];
            bus(1'b1, 8'h00, 32'h00000800 | ((k % 3) << 8) | ((k / 3) << 10));
            enc0.pulses(k % 3, h, l, 3);
            rd("pw_high", 8'h10, 32'(h));
            rd("pw_low", 8'h14, 32'(l));
            rd("period", 8'h18, 32'(h + l));
        end
        bus(1'b1, 8'h04, 32'h00000004);
        rd("pw_cleared", 8'h10, 32'h00000000);
        hi_q <= seed[8:0];
        rd("din", 8'h40, {20'h00000, seed[8:0], iso_w[2:0]});
        chk("iso_level", {20'h00000, isolated_level_out}, {20'h00000, seed[8:0], iso_w[2:0]});
        chk("ser_level", {31'h00000000, serial_data_sync_out}, {31'h00000000, r0_w});
        rd("unmapped", 8'h44, 32'h00000000);
        finish_test();
    end
endmodule : tb_top
